// [amt_pkg.sv]
package amt_pkg;

    // register map
    localparam logic [7:0] ADDR_FEATURE_TWO = 8'h0e;
    localparam logic [7:0] ADDR_INIT_KEY = 8'h0f;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h10;

    // feature_control_two fields
    localparam int FEAT_STREAM_BIT = 5;
    localparam int FEAT_EDGE_SEL_BIT = 6;
    localparam int FEAT_COUNTED_BURST_MODE_EN_BIT = 7;
    localparam logic [7:0] FEAT_RESET = 8'h00;

    // init_key codes
    localparam logic [7:0] INIT_WRITE_KEY = 8'h42;
    localparam logic [7:0] INIT_RD_STARTING = 8'h45;
    localparam logic [7:0] INIT_RD_READY = 8'h40;
    localparam logic [7:0] INIT_RD_DONE = 8'h43;

    // operating_mode_control fields
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_WATCH = 3'h2;
    localparam logic [2:0] MODE_CONT = 3'h5;
    localparam logic [2:0] MODE_WATCH_PLUS = 3'h6;
    localparam logic [2:0] MODE_BURST = 3'h7;
    localparam logic [7:0] BURST_ENDLESS = 8'hff;

    // timing
    localparam int CLOCK_HZ = 10_000_000;
    localparam int STATUS_LAG_MS = 2;
    localparam int STATUS_LAG_CYC = STATUS_LAG_MS * (CLOCK_HZ / 1000);
    localparam int STARTUP_US = 100;
    localparam int STARTUP_CYC = STARTUP_US * (CLOCK_HZ / 1_000_000);
    localparam int HEARTBEAT_DIV = 10;
    localparam int MODE_APPLY_BEATS = 2;
    localparam int BUF_DEPTH = 32;

    typedef struct packed {
        logic one_shot_command;
        logic third_axis_off;
        logic second_axis_off;
        logic first_axis_off;
        logic unused_bit;
        logic [2:0] mode_select_field;
    } amt_mode_ctrl_t;

    typedef struct packed {
        logic outside_trigger_enable;
        logic outside_trigger_edge_select;
        logic stream_enable;
        logic [4:0] other_bits;
    } amt_feature_t;

    typedef enum logic [5:0] {
        ST_SLEEP = 6'h01,
        ST_STANDBY = 6'h02,
        ST_WATCH = 6'h04,
        ST_CONT = 6'h08,
        ST_WATCH_PLUS = 6'h10,
        ST_BURST = 6'h20
    } amt_state_t;

    typedef struct packed {
        logic sniff_on;
        logic sampling_on;
        logic buffer_on;
        logic clocks_on;
        logic power_down;
    } amt_power_t;

endpackage : amt_pkg

// [amt_counted_burst_mode_edge.sv]
`timescale 1ns/100ps
module amt_counted_burst_mode_edge (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_in,
    input wire logic enable,
    input wire logic edge_select,
    output logic counted_burst_mode_pulse
);
    logic sync1_r;
    logic sync2_r;
    logic last_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_r <= 1'b1;
        end else begin
            last_r <= sync2_r;
        end
    end

    // 0 falling, 1 rising
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            counted_burst_mode_pulse <= 1'b0;
        end else begin
            counted_burst_mode_pulse <= enable & (edge_select ? (sync2_r & ~last_r) : (~sync2_r & last_r));
        end
    end
endmodule : amt_counted_burst_mode_edge

// [amt_sample_buf.sv]
`timescale 1ns/100ps
module amt_sample_buf #(
    parameter int DEPTH = amt_pkg::BUF_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic buf_enable,
    input wire logic stream_enable,
    input wire logic push,
    input wire logic pop,
    output logic [$clog2(DEPTH+1)-1:0] level,
    output logic full,
    output logic dropped,
    output logic refused
);
    localparam logic [$clog2(DEPTH+1)-1:0] LVL_MAX = ($clog2(DEPTH+1))'(DEPTH);
    logic do_pop;
    logic is_full;

    assign is_full = (level == LVL_MAX);
    assign do_pop = pop & (level != '0);

    // occupancy only; sample storage lives in the datapath
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level <= '0;
        end else if (!buf_enable) begin
            level <= '0;
        end else if (push & ~is_full & ~do_pop) begin
            level <= level + 1'b1;
        end else if (do_pop & ~push) begin
            level <= level - 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            full <= 1'b0;
            dropped <= 1'b0;
            refused <= 1'b0;
        end else begin
            full <= buf_enable & (level == LVL_MAX) & ~(do_pop & ~push);
            dropped <= buf_enable & push & is_full & ~do_pop & stream_enable;
            refused <= buf_enable & push & is_full & ~do_pop & ~stream_enable;
        end
    end
endmodule : amt_sample_buf

// [accel_mode_trigger_control.sv]
`timescale 1ns/100ps
// How it works
// - stream on and buffer full: oldest sample dropped so newest is kept
// - stream off, the reset default: full buffer refuses new samples
// - stream bit matters only while the buffer enable is one
// - stream behaviour is the same for every host interface
// - edge select zero picks falling edges, one picks rising edges
// - trigger enable turns the interrupt pin into a trigger input
// - init reads 0x45 starting, 0x40 ready, 0x43 after key written
// - written mode change completes on the second heartbeat edge after the write
// - reported mode lags the live mode by 2 ms
// - hardware may set or clear the mode field on its own
// - mode control register is write-only, resets to zero
// - code 000 is deep sleep: clocks stopped, partly powered down
// - code 001 is standby: clocks run, no sampling
// - code 010 watches activity only, then jumps to continuous sampling
// - code 101 samples continuously with activity watch off
// - code 110 runs activity watch, sampling and buffer together
// - code 111 takes a counted burst or runs endless, then sleeps
// - one-shot starts from standby only; 255 endless, else back to standby
// - each axis off bit turns its axis off when one
module accel_mode_trigger_control #(
    parameter int STATUS_LAG = amt_pkg::STATUS_LAG_CYC,
    parameter int STARTUP = amt_pkg::STARTUP_CYC,
    parameter int HB_DIV = amt_pkg::HEARTBEAT_DIV,
    parameter int DEPTH = amt_pkg::BUF_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,

    input wire logic buf_enable,
    input wire logic buf_pop,
    input wire logic [7:0] burst_sample_count,
    input wire logic sample_tick,
    input wire logic activity_seen,

    input wire logic irq_request,
    input wire logic irq_out_pin_in,
    output logic irq_out_pin_out,
    output logic irq_out_pin_oe,

    output logic sample_take,
    output logic [2:0] axis_on,
    output amt_pkg::amt_power_t power,
    output logic [2:0] status_mode,

    output logic [$clog2(DEPTH+1)-1:0] buf_level,
    output logic buf_full,
    output logic buf_dropped,
    output logic buf_refused
);
    localparam int HBW = $clog2(HB_DIV + 1);
    localparam int LAGW = $clog2(STATUS_LAG + 1);
    localparam int STW = $clog2(STARTUP + 1);

    amt_pkg::amt_feature_t feat_r;
    amt_pkg::amt_mode_ctrl_t mctl_r;

    amt_pkg::amt_state_t state_r;
    amt_pkg::amt_state_t state_nxt;

    logic [STW-1:0] start_cnt_r;
    logic starting_r;
    logic key_done_r;

    logic [HBW-1:0] hb_cnt_r;
    logic hb_tick;
    logic [1:0] beats_r;
    logic pend_r;

    logic [LAGW-1:0] lag_cnt_r;
    logic [2:0] lag_code_r;

    logic [7:0] burst_left_r;
    logic burst_endless_r;
    logic burst_from_cmd_r;

    logic counted_burst_mode_pulse;
    logic take;
    logic wr_mode;
    logic wr_feat;
    logic cmd_ok;

    function automatic amt_pkg::amt_state_t code_to_state(input logic [2:0] code);
        unique case (code)
            amt_pkg::MODE_SLEEP: code_to_state = amt_pkg::ST_SLEEP;
            amt_pkg::MODE_WATCH: code_to_state = amt_pkg::ST_WATCH;
            amt_pkg::MODE_CONT: code_to_state = amt_pkg::ST_CONT;
            amt_pkg::MODE_WATCH_PLUS: code_to_state = amt_pkg::ST_WATCH_PLUS;
            amt_pkg::MODE_BURST: code_to_state = amt_pkg::ST_BURST;
            // reserved codes park in standby
            default: code_to_state = amt_pkg::ST_STANDBY;
        endcase
    endfunction : code_to_state

    function automatic logic [2:0] state_to_code(input amt_pkg::amt_state_t st);
        unique case (st)
            amt_pkg::ST_SLEEP: state_to_code = amt_pkg::MODE_SLEEP;
            amt_pkg::ST_STANDBY: state_to_code = amt_pkg::MODE_STANDBY;
            amt_pkg::ST_WATCH: state_to_code = amt_pkg::MODE_WATCH;
            amt_pkg::ST_CONT: state_to_code = amt_pkg::MODE_CONT;
            amt_pkg::ST_WATCH_PLUS: state_to_code = amt_pkg::MODE_WATCH_PLUS;
            amt_pkg::ST_BURST: state_to_code = amt_pkg::MODE_BURST;
            default: state_to_code = amt_pkg::MODE_SLEEP;
        endcase
    endfunction : state_to_code

    assign wr_mode = reg_wr & (reg_addr == amt_pkg::ADDR_MODE_CTRL);
    assign wr_feat = reg_wr & (reg_addr == amt_pkg::ADDR_FEATURE_TWO);
    assign cmd_ok = wr_mode & reg_wdata[7] & (state_r == amt_pkg::ST_STANDBY);

    // feature register; the host link type plays no part here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            feat_r <= amt_pkg::FEAT_RESET;
        end else if (wr_feat) begin
            feat_r <= reg_wdata;
        end
    end

    // start-up sequence and init key
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_cnt_r <= '0;
            starting_r <= 1'b1;
        end else if (starting_r) begin
            start_cnt_r <= start_cnt_r + 1'b1;
            starting_r <= (start_cnt_r != STW'(STARTUP - 1));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_done_r <= 1'b0;
        end else if (reg_wr & (reg_addr == amt_pkg::ADDR_INIT_KEY) &
                     (reg_wdata == amt_pkg::INIT_WRITE_KEY)) begin
            key_done_r <= 1'b1;
        end
    end

    // read port; mode control reads as zero since it is write-only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    amt_pkg::ADDR_FEATURE_TWO: reg_rdata <= feat_r;
                    amt_pkg::ADDR_INIT_KEY: reg_rdata <= key_done_r ? amt_pkg::INIT_RD_DONE :
                        (starting_r ? amt_pkg::INIT_RD_STARTING : amt_pkg::INIT_RD_READY);
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // heartbeat divider
    assign hb_tick = (hb_cnt_r == HBW'(HB_DIV - 1));
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hb_cnt_r <= '0;
        end else begin
            hb_cnt_r <= hb_tick ? '0 : hb_cnt_r + 1'b1;
        end
    end

    // mode applied on second heartbeat after write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
            beats_r <= '0;
        end else if (wr_mode & ~reg_wdata[7]) begin
            pend_r <= 1'b1;
            beats_r <= '0;
        end else if (pend_r & hb_tick) begin
            beats_r <= beats_r + 1'b1;
            pend_r <= (beats_r != 2'(amt_pkg::MODE_APPLY_BEATS - 1));
        end
    end

    // mode control register with hardware override of the field
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mctl_r <= amt_pkg::MODE_CTRL_RESET;
        end else if (wr_mode) begin
            mctl_r <= reg_wdata;
            if (reg_wdata[7]) begin
                mctl_r.mode_select_field <= cmd_ok ? amt_pkg::MODE_BURST :
                    mctl_r.mode_select_field;
            end
        end else if (state_nxt != state_r) begin
            mctl_r.mode_select_field <= state_to_code(state_nxt);
        end
    end

    always_comb begin
        state_nxt = state_r;
        if (pend_r & hb_tick & (beats_r == 2'(amt_pkg::MODE_APPLY_BEATS - 1))) begin
            state_nxt = code_to_state(mctl_r.mode_select_field);
        end else if (cmd_ok) begin
            state_nxt = amt_pkg::ST_BURST;
        end else begin
            unique case (state_r)
                amt_pkg::ST_WATCH: begin
                    if (activity_seen) begin
                        state_nxt = amt_pkg::ST_CONT;
                    end
                end
                amt_pkg::ST_BURST: begin
                    if (take & ~burst_endless_r & (burst_left_r == 8'h01)) begin
                        state_nxt = burst_from_cmd_r ? amt_pkg::ST_STANDBY :
                            amt_pkg::ST_SLEEP;
                    end
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= amt_pkg::ST_SLEEP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // burst counter, loaded on entry to the counted mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            burst_left_r <= 8'h00;
            burst_endless_r <= 1'b0;
            burst_from_cmd_r <= 1'b0;
        end else if (state_nxt == amt_pkg::ST_BURST && state_r != amt_pkg::ST_BURST) begin
            burst_left_r <= burst_sample_count;
            burst_endless_r <= (burst_sample_count == amt_pkg::BURST_ENDLESS);
            burst_from_cmd_r <= cmd_ok;
        end else if (take & (state_r == amt_pkg::ST_BURST) & (burst_left_r != 8'h00)) begin
            burst_left_r <= burst_left_r - 1'b1;
        end
    end

    // pin turns into a trigger input; no drive while enabled
    amt_counted_burst_mode_edge u_edge (
        .clock(clock),
        .rst(rst),
        .pin_in(irq_out_pin_in),
        .enable(feat_r.outside_trigger_enable),
        .edge_select(feat_r.outside_trigger_edge_select),
        .counted_burst_mode_pulse(counted_burst_mode_pulse)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_out_pin_out <= 1'b1;
            irq_out_pin_oe <= 1'b0;
        end else begin
            // open drain, active low request
            irq_out_pin_out <= 1'b0;
            irq_out_pin_oe <= irq_request & ~feat_r.outside_trigger_enable;
        end
    end

    // outside trigger paces counted mode
    always_comb begin
        unique case (state_r)
            amt_pkg::ST_CONT, amt_pkg::ST_WATCH_PLUS: take = sample_tick;
            amt_pkg::ST_BURST: take = feat_r.outside_trigger_enable ? counted_burst_mode_pulse : sample_tick;
            default: take = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample_take <= 1'b0;
            axis_on <= 3'h0;
            power <= '0;
        end else begin
            sample_take <= take;
            axis_on <= ~{mctl_r.third_axis_off, mctl_r.second_axis_off,
                         mctl_r.first_axis_off};
            power.sniff_on <= (state_r == amt_pkg::ST_WATCH) |
                              (state_r == amt_pkg::ST_WATCH_PLUS);
            power.sampling_on <= (state_r == amt_pkg::ST_CONT) |
                                 (state_r == amt_pkg::ST_WATCH_PLUS) |
                                 (state_r == amt_pkg::ST_BURST);
            power.buffer_on <= buf_enable & (state_r != amt_pkg::ST_WATCH);
            power.clocks_on <= (state_r != amt_pkg::ST_SLEEP);
            power.power_down <= (state_r == amt_pkg::ST_SLEEP);
        end
    end

    // reported mode lags the live mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lag_cnt_r <= '0;
            lag_code_r <= amt_pkg::MODE_SLEEP;
            status_mode <= amt_pkg::MODE_SLEEP;
        end else if (state_to_code(state_r) != lag_code_r) begin
            lag_code_r <= state_to_code(state_r);
            lag_cnt_r <= '0;
        end else if (status_mode != lag_code_r) begin
            if (lag_cnt_r == LAGW'(STATUS_LAG - 1)) begin
                status_mode <= lag_code_r;
            end else begin
                lag_cnt_r <= lag_cnt_r + 1'b1;
            end
        end
    end

    amt_sample_buf #(
        .DEPTH(DEPTH)
    ) u_buf (
        .clock(clock),
        .rst(rst),
        .buf_enable(buf_enable & power.buffer_on),
        .stream_enable(feat_r.stream_enable),
        .push(sample_take),
        .pop(buf_pop),
        .level(buf_level),
        .full(buf_full),
        .dropped(buf_dropped),
        .refused(buf_refused)
    );
endmodule : accel_mode_trigger_control

// [amt_ctl_props.sv]
`timescale 1ns/100ps
module amt_ctl_props #(
    parameter int HB_DIV = 10,
    parameter int DEPTH = 32
) (
    input logic clock,
    input logic rst,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid,
    input amt_pkg::amt_power_t power,
    input logic irq_out_pin_oe,
    input logic [$clog2(DEPTH+1)-1:0] buf_level,
    input logic buf_full,
    input logic buf_dropped,
    input logic buf_refused
);
    localparam int APPLY_MAX = 3 * HB_DIV + 2;
    logic key_written_r;
    wire mode_wr = reg_wr && reg_addr == amt_pkg::ADDR_MODE_CTRL && !reg_wdata[7];
    wire init_rd = reg_rd && reg_addr == amt_pkg::ADDR_INIT_KEY;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_written_r <= 1'h0;
        end else if (reg_wr && reg_addr == amt_pkg::ADDR_INIT_KEY
                     && reg_wdata == amt_pkg::INIT_WRITE_KEY) begin
            key_written_r <= 1'h1;
        end
    end

    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("no read answer");
    a_mode_reads_zero: assert property (
        reg_rd && reg_addr == amt_pkg::ADDR_MODE_CTRL |=> reg_rdata == 8'h00)
        else $error("mode reg readable");
    a_init_early_codes: assert property (
        init_rd && !key_written_r |=> reg_rdata == 8'h45 || reg_rdata == 8'h40)
        else $error("early init code");
    a_init_done_code: assert property (
        init_rd && key_written_r |=> reg_rdata == 8'h43)
        else $error("done init code");
    a_cont_mode_apply: assert property (
        mode_wr && reg_wdata[2:0] == 3'h5
        |-> ##[1:APPLY_MAX] power.sampling_on && !power.sniff_on)
        else $error("cont mode late");
    a_sleep_mode_apply: assert property (
        mode_wr && reg_wdata[2:0] == 3'h0
        |-> ##[1:APPLY_MAX] power.power_down && !power.clocks_on)
        else $error("sleep mode late");
    a_counted_burst_mode_pin_released: assert property (
        reg_wr && reg_addr == amt_pkg::ADDR_FEATURE_TWO && reg_wdata[7]
        |-> ##[1:2] !irq_out_pin_oe)
        else $error("pin still driven");
    a_drop_keeps_full: assert property (
        buf_dropped |-> buf_full && $stable(buf_level) && !buf_refused)
        else $error("drop not full");
    a_refuse_when_full: assert property (
        buf_refused |-> buf_full && $stable(buf_level))
        else $error("refuse not full");

    c_dropped: cover property (buf_dropped);
    c_refused: cover property (buf_refused);
    c_key_done: cover property (init_rd && key_written_r);
endmodule : amt_ctl_props

bind accel_mode_trigger_control amt_ctl_props #(.HB_DIV(HB_DIV), .DEPTH(DEPTH)) amt_ctl_props_inst (
    .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .power, .irq_out_pin_oe, .buf_level, .buf_full, .buf_dropped, .buf_refused
);

// [amt_host_model.sv]
`timescale 1ns/100ps
module amt_host_model #(
    parameter int HB_DIV = 10
) (
    input logic clock,
    input logic reg_rvalid,
    input logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock) #1;
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clock) #1;
        reg_rd = 1'h1;
        reg_addr = a;
        @(posedge clock) #1;
        reg_rd = 1'h0;
        reg_addr = ~a;
        ok = 1'h0;
        d = 8'hxx;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'h1) begin
                ok = 1'h1;
                d = reg_rdata;
            end else begin
                @(posedge clock) #1;
            end
        end
    endtask : rd

    task automatic set_mode(input logic [2:0] code);
        if (code == 3'h3 || code == 3'h4) begin
            return;
        end
        wr(amt_pkg::ADDR_MODE_CTRL, {5'h00, code});
        repeat (2 * HB_DIV + 3) @(posedge clock);
        #1;
    endtask : set_mode

    task automatic arm_trigger(input logic edge_sel);
        wr(amt_pkg::ADDR_FEATURE_TWO, {1'h1, edge_sel, 6'h00});
        set_mode(amt_pkg::MODE_BURST);
    endtask : arm_trigger
endmodule : amt_host_model

// [accel_mode_trigger_control_test.sv]
`timescale 1ns/100ps
module accel_mode_trigger_control_test;
    localparam int HB = 4;
    localparam int LAG = 20;
    localparam int DEP = 32;
    logic clock, rst, reg_wr, reg_rd, reg_rvalid, buf_enable, buf_pop, sample_tick;
    logic activity_seen, irq_request, pin_drive, irq_out_pin_oe, sample_take, po;
    logic buf_full, buf_dropped, buf_refused, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_sample_count, rv;
    logic [2:0] axis_on, status_mode, prev;
    logic [$clog2(DEP+1)-1:0] buf_level;
    amt_pkg::amt_power_t power;
    int n_fail = 0;
    int checks = 0;
    int takes, drops, refs;
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
    logic [4:0] pexp [5] = '{5'h06, 5'h12, 5'h0e, 5'h1e, 5'h05};
    wire pin_level = irq_out_pin_oe ? po : pin_drive;

    accel_mode_trigger_control #(
        .STATUS_LAG(LAG), .STARTUP(10), .HB_DIV(HB), .DEPTH(DEP)
    ) accel_mode_trigger_control_inst (
        .clock, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .buf_enable, .buf_pop, .burst_sample_count, .sample_tick, .activity_seen,
        .irq_request, .irq_out_pin_in(pin_level), .irq_out_pin_out(po), .irq_out_pin_oe,
        .sample_take, .axis_on, .power, .status_mode, .buf_level, .buf_full,
        .buf_dropped, .buf_refused
    );

    amt_host_model #(.HB_DIV(HB)) amt_host_model_inst (
        .clock, .reg_rvalid, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata
    );

    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic compare(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : compare

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        amt_host_model_inst.rd(a, rv, ok);
        if (!ok) begin
            n_fail++;
            report_and_stop();
        end else begin
            compare(what, rv, exp);
        end
    endtask : rd_chk

    task automatic watch(input int n);
        repeat (n) begin
            cyc(1);
            takes += int'(sample_take === 1'h1);
            drops += int'(buf_dropped === 1'h1);
            refs += int'(buf_refused === 1'h1);
        end
    endtask : watch

    task automatic ticks(input int n);
        takes = 0;
        drops = 0;
        refs = 0;
        repeat (n) begin
            sample_tick = 1'h1;
            watch(1);
            sample_tick = 1'h0;
            watch(1);
        end
    endtask : ticks

    task automatic pin_edge(input logic v);
        ticks(0);
        pin_drive = v;
        watch(8);
    endtask : pin_edge

    initial begin
        rst = 1'h1;
        buf_enable = 1'h1;
        buf_pop = 1'h0;
        burst_sample_count = 8'h03;
        sample_tick = 1'h0;
        activity_seen = 1'h0;
        irq_request = 1'h1;
        pin_drive = 1'h1;
        cyc(6);
        rst = 1'h0;
        cyc(1);
        compare("status", status_mode, 8'h00);
        rd_chk("init", amt_pkg::ADDR_INIT_KEY, 8'h45);
        cyc(12);
        rd_chk("init", amt_pkg::ADDR_INIT_KEY, 8'h40);
        amt_host_model_inst.wr(amt_pkg::ADDR_INIT_KEY, amt_pkg::INIT_WRITE_KEY);
        rd_chk("init", amt_pkg::ADDR_INIT_KEY, 8'h43);
        rd_chk("mode rd", amt_pkg::ADDR_MODE_CTRL, 8'h00);
        rd_chk("unmapped", 8'h33, 8'h00);
        $display("init done");
        prev = 3'h0;
        for (int i = 0; i < 5; i++) begin
            amt_host_model_inst.set_mode(codes[i]);
            compare("pwr", power, pexp[i]);
            compare("lag", status_mode, prev);
            cyc(LAG + 2);
            compare("status", status_mode, codes[i]);
            prev = codes[i];
            if (codes[i] == amt_pkg::MODE_WATCH) begin
                activity_seen = 1'h1;
                cyc(1);
                activity_seen = 1'h0;
                cyc(3);
                compare("wake", power.sampling_on, 8'h01);
                cyc(LAG + 3);
                prev = amt_pkg::MODE_CONT;
            end
        end
        $display("modes done");
        amt_host_model_inst.set_mode(amt_pkg::MODE_CONT);
        ticks(DEP);
        compare("takes", takes, DEP);
        cyc(1);
        compare("full", buf_full, 8'h01);
        ticks(1);
        compare("refused", refs, 8'h01);
        compare("level", buf_level, DEP);
        amt_host_model_inst.wr(amt_pkg::ADDR_FEATURE_TWO, 8'h20);
        ticks(1);
        compare("dropped", drops, 8'h01);
        compare("level", buf_level, DEP);
        buf_pop = 1'h1;
        cyc(1);
        buf_pop = 1'h0;
        cyc(1);
        compare("popped", buf_level, DEP - 1);
        buf_enable = 1'h0;
        ticks(2);
        compare("no drop", drops, 8'h00);
        buf_enable = 1'h1;
        $display("buffer done");
        amt_host_model_inst.wr(amt_pkg::ADDR_MODE_CTRL, 8'h75);
        cyc(2 * HB + 3);
        compare("axis", axis_on, 8'h00);
        amt_host_model_inst.wr(amt_pkg::ADDR_MODE_CTRL, 8'h25);
        cyc(2 * HB + 3);
        compare("axis", axis_on, 8'h05);
        amt_host_model_inst.set_mode(amt_pkg::MODE_STANDBY);
        amt_host_model_inst.wr(amt_pkg::ADDR_MODE_CTRL, 8'h81);
        ticks(5);
        compare("shot", takes, 8'h03);
        compare("standby", power & 5'h0b, 8'h02);
        amt_host_model_inst.set_mode(amt_pkg::MODE_SLEEP);
        amt_host_model_inst.wr(amt_pkg::ADDR_MODE_CTRL, 8'h81);
        ticks(2);
        compare("no shot", takes, 8'h00);
        burst_sample_count = 8'h02;
        amt_host_model_inst.set_mode(amt_pkg::MODE_BURST);
        ticks(4);
        compare("burst", takes, 8'h02);
        cyc(2);
        compare("sleep", power & 5'h0b, 8'h01);
        $display("burst done");
        compare("pin oe", irq_out_pin_oe, 8'h01);
        compare("pin out", po, 8'h00);
        burst_sample_count = 8'hff;
        amt_host_model_inst.arm_trigger(1'h0);
        compare("pin oe", irq_out_pin_oe, 8'h00);
        pin_edge(1'h0);
        compare("fall", takes, 8'h01);
        pin_edge(1'h1);
        compare("rise", takes, 8'h00);
        amt_host_model_inst.arm_trigger(1'h1);
        pin_edge(1'h0);
        compare("fall", takes, 8'h00);
        pin_edge(1'h1);
        compare("rise", takes, 8'h01);
        $display("trigger done");
        report_and_stop();
    end
endmodule : accel_mode_trigger_control_test
